// file: design/o2_trim_release_sequencer.sv
// oxygen trim and alarm activation, locking and release sequencer
`timescale 1ns/1ns
module o2_trim_release_sequencer
   import o2_seq_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int HEAT_TICKS = HEAT_WAIT_TICKS
)
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic FUEL_OIL_IN,
   input wire logic [LOAD_W-1:0] LOAD_IN,
   input wire logic [LOAD_W-1:0] LOWFIRE_ADAPT_POINT_GAS_IN,
   input wire logic [LOAD_W-1:0] LOWFIRE_ADAPT_POINT_OIL_IN,
   input wire logic [LOAD_W-1:0] TRIM_LOAD_THRESHOLD_GAS_IN,
   input wire logic [LOAD_W-1:0] TRIM_LOAD_THRESHOLD_OIL_IN,
   input wire logic [2:0] OXYGEN_OPERATING_MODE_IN,
   input wire logic [1:0] START_MODE_IN,
   input wire logic [TEMP_W-1:0] SENSOR_TEMP_IN,
   input wire logic SENSOR_TEST_OK_IN,
   input wire logic POWER_RESTORED_IN,
   input wire logic [7:0] PHASE_IN,
   input wire logic [7:0] LOCK_TIME_CONSTANT_MULTIPLE_IN,
   input wire logic [15:0] TAU_LOWFIRE_IN,
   input wire logic O2_BELOW_SETPOINT_IN,
   input wire logic AIR_AT_LIMIT_IN,
   input wire logic signed [MV_W-1:0] START_VALUE_IN,
   input wire logic signed [TEMP_W-1:0] SUPPLY_AIR_TEMP_IN,
   input wire logic signed [TEMP_W-1:0] ADJUSTMENT_AIR_TEMPERATURE_IN,
   input wire logic signed [3:0] TEMP_GAIN_IN,
   input wire logic signed [MV_W-1:0] MANIPULATED_VALUE_OFFSET_GAS_IN,
   input wire logic signed [MV_W-1:0] MANIPULATED_VALUE_OFFSET_OIL_IN,
   input wire logic signed [MV_W-1:0] INITIALIZATION_OFFSET_GAS_IN,
   input wire logic signed [MV_W-1:0] INITIALIZATION_OFFSET_OIL_IN,
   output logic STARTUP_ALLOWED_OUT,
   output logic SENSOR_READY_OUT,
   output logic TRIM_ACTIVE_OUT,
   output logic TRIM_LOCKED_OUT,
   output logic ALARM_ACTIVE_OUT,
   output logic CURVE_ONLY_OUT,
   output logic TRIM_INIT_OUT,
   output logic signed [MV_W-1:0] TRIM_INIT_VALUE_OUT,
   output logic USE_IGNITION_POSITIONS_OUT,
   output logic AIR_ABOVE_CURVE_OUT,
   output logic FUEL_ADJUST_OUT
);
   seq_state_t state;
   heat_state_t heat;
   logic [31:0] prescale;
   logic tick;
   logic first_cycle;
   logic load_inhibit;
   logic was_oper;
   logic lock_start;
   logic lock_abort;
   logic [CNT_W-1:0] lock_count;
   logic lock_busy;
   logic lock_done;
   logic soak_start;
   logic soak_busy;
   logic soak_done;
   logic [LOAD_W-1:0] low_pt;
   logic [LOAD_W-1:0] thr;
   logic [LOAD_W-1:0] gate;
   logic [LOAD_W:0] reenable;
   logic trim_mode;
   logic alarm_mode;
   logic [1:0] eff_start;
   logic running;
   logic entering_oper;
   logic sensor_hot;
   logic trim_allowed;
   logic next_init;
   logic signed [MV_W-1:0] next_init_value;
   logic signed [MV_W-1:0] mv_offset;
   logic signed [MV_W-1:0] init_offset;
   logic signed [MV_W-1:0] comp_value;

   if (TICK_CYC < 1 || HEAT_TICKS < 1)
   begin : bad_counts
      $error("tick and soak counts must be positive");
   end

   function automatic logic [LOAD_W-1:0] pick_load(input logic oil,
      input logic [LOAD_W-1:0] gas_v, input logic [LOAD_W-1:0] oil_v);
      pick_load = oil ? oil_v : gas_v;
   endfunction : pick_load

   function automatic logic signed [MV_W-1:0] pick_mv(input logic oil,
      input logic signed [MV_W-1:0] gas_v, input logic signed [MV_W-1:0] oil_v);
      pick_mv = oil ? oil_v : gas_v;
   endfunction : pick_mv

   function automatic logic is_ign_phase(input logic [7:0] ph);
      is_ign_phase = (ph == PHASE_IGN_A) || (ph == PHASE_IGN_B);
   endfunction : is_ign_phase

   // per-fuel selection of thresholds and offsets
   assign low_pt = pick_load(FUEL_OIL_IN, LOWFIRE_ADAPT_POINT_GAS_IN, LOWFIRE_ADAPT_POINT_OIL_IN);
   assign thr = pick_load(FUEL_OIL_IN, TRIM_LOAD_THRESHOLD_GAS_IN, TRIM_LOAD_THRESHOLD_OIL_IN);
   assign mv_offset = pick_mv(FUEL_OIL_IN, MANIPULATED_VALUE_OFFSET_GAS_IN,
      MANIPULATED_VALUE_OFFSET_OIL_IN);
   assign init_offset = pick_mv(FUEL_OIL_IN, INITIALIZATION_OFFSET_GAS_IN,
      INITIALIZATION_OFFSET_OIL_IN);

   // the higher of the two thresholds governs both drop-out and return
   assign gate = (low_pt > thr) ? low_pt : thr;
   assign reenable = {1'b0, gate} + {1'b0, LOAD_HYST};

   assign trim_mode = (OXYGEN_OPERATING_MODE_IN == MODE_TRIM_AND_ALARM) ||
      (OXYGEN_OPERATING_MODE_IN == MODE_AUTO_DEACTIVATING);
   assign alarm_mode = trim_mode || (OXYGEN_OPERATING_MODE_IN == MODE_ALARM_ONLY);
   assign eff_start = trim_mode ? START_MODE_IN : START_STANDARD;
   assign running = (PHASE_IN >= PHASE_IGN_A);
   assign entering_oper = (PHASE_IN == PHASE_OPER) && !was_oper;
   assign sensor_hot = (SENSOR_TEMP_IN >= SENSOR_OPER_TEMP);

   // auto-deactivating mode waits for heat and sensor test before trimming
   assign trim_allowed = (OXYGEN_OPERATING_MODE_IN == MODE_AUTO_DEACTIVATING) ?
      (SENSOR_READY_OUT && SENSOR_TEST_OK_IN) : (OXYGEN_OPERATING_MODE_IN == MODE_TRIM_AND_ALARM);

   // narrow gain keeps the product inside the 16-bit manipulated value
   assign comp_value = MV_W'((SUPPLY_AIR_TEMP_IN - ADJUSTMENT_AIR_TEMPERATURE_IN) * TEMP_GAIN_IN);

   // common tick for every interval
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN || prescale >= 32'(TICK_CYC - 1))
         prescale <= '0;
      else
         prescale <= prescale + 32'h00000001;
   end
   assign tick = (prescale == 32'(TICK_CYC - 1));

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         first_cycle <= 1'b1;
         was_oper <= 1'b0;
      end
      else
      begin
         first_cycle <= 1'b0;
         was_oper <= (PHASE_IN == PHASE_OPER);
      end
   end

   // load gate with hysteresis on the way back up
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
         load_inhibit <= 1'b1;
      else if (LOAD_IN < gate)
         load_inhibit <= 1'b1;
      else if ({1'b0, LOAD_IN} >= reenable)
         load_inhibit <= 1'b0;
   end

   // sensor heat-up; warm-restart temperature sampled one edge after release
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
         heat <= H_COLD;
      else if (first_cycle)
         heat <= (POWER_RESTORED_IN && SENSOR_TEMP_IN > SENSOR_WARM_TEMP) ? H_READY : H_COLD;
      else
      begin
         case (heat)
            H_COLD: if (sensor_hot) heat <= H_SOAK;
            H_SOAK:
            begin
               if (!sensor_hot)
                  heat <= H_COLD;
               else if (soak_done)
                  heat <= H_READY;
            end
            H_READY: heat <= H_READY;
            default: heat <= H_COLD;
         endcase
      end
   end
   assign soak_start = (heat == H_COLD) && sensor_hot && !first_cycle;

   o2_interval_timer #(.W(CNT_W)) soak_timer (
      .clk(CLK_IN),
      .rst_b(RST_B_IN),
      .tick_in(tick),
      .start_in(soak_start),
      .abort_in(heat != H_SOAK && !soak_start),
      .count_in(CNT_W'(HEAT_TICKS)),
      .busy_out(soak_busy),
      .done_out(soak_done)
   );

   // release sequence
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN || !running || !alarm_mode)
         state <= S_IDLE;
      else
      begin
         case (state)
            S_IDLE:
            begin
               if (is_ign_phase(PHASE_IN))
                  state <= (eff_start == START_STANDARD) ? S_PHASE_LOCK : S_START_LOCK;
               else if (entering_oper)
                  state <= S_START_LOCK;
            end
            S_PHASE_LOCK:
            begin
               if (entering_oper)
                  state <= S_START_LOCK;
            end
            S_START_LOCK:
            begin
               // special starts may end the lock early on low oxygen
               if (eff_start != START_STANDARD && (lock_done || O2_BELOW_SETPOINT_IN))
                  state <= S_RELEASED;
               else if (eff_start == START_STANDARD && lock_done)
                  state <= S_INIT_WAIT;
            end
            S_INIT_WAIT:
            begin
               if (lock_done)
                  state <= S_RELEASED;
            end
            S_RELEASED:
            begin
               if (load_inhibit)
                  state <= S_HOLD;
            end
            S_HOLD:
            begin
               if (!load_inhibit)
                  state <= S_RELEASED;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // lock timer loads multiple x tau, or 4 x tau for the release wait
   always_comb
   begin
      lock_start = 1'b0;
      lock_count = CNT_W'(LOCK_TIME_CONSTANT_MULTIPLE_IN * TAU_LOWFIRE_IN);
      if ((state == S_IDLE || state == S_PHASE_LOCK) && running && alarm_mode)
         lock_start = entering_oper || (is_ign_phase(PHASE_IN) && state == S_IDLE &&
            eff_start != START_STANDARD);
      if (state == S_START_LOCK && eff_start == START_STANDARD && lock_done)
      begin
         lock_start = 1'b1;
         lock_count = CNT_W'(RELEASE_TAU_MULT * TAU_LOWFIRE_IN);
      end
   end
   assign lock_abort = (state == S_RELEASED) || (state == S_HOLD) || !running;

   o2_interval_timer #(.W(CNT_W)) lock_timer (
      .clk(CLK_IN),
      .rst_b(RST_B_IN),
      .tick_in(tick),
      .start_in(lock_start),
      .abort_in(lock_abort && !lock_start),
      .count_in(lock_count),
      .busy_out(lock_busy),
      .done_out(lock_done)
   );

   // initialization requests and their value
   always_comb
   begin
      next_init = 1'b0;
      next_init_value = TRIM_INIT_VALUE_OUT;
      if (state == S_START_LOCK && eff_start == START_STANDARD && lock_done)
      begin
         next_init = 1'b1;
         next_init_value = MV_W'(START_VALUE_IN + mv_offset);
      end
      else if (state == S_IDLE && running && alarm_mode && is_ign_phase(PHASE_IN) &&
         eff_start != START_STANDARD)
      begin
         // a special start initializes here when it enters an ignition phase from idle; going from idle straight to operation skips it
         next_init = 1'b1;
         if (eff_start == START_POS_UNCOMP)
            next_init_value = init_offset;
         else
            next_init_value = MV_W'(comp_value + init_offset);
      end
      else if (state == S_HOLD && !load_inhibit)
      begin
         next_init = 1'b1;
         next_init_value = (eff_start == START_STANDARD) ? MV_W'(START_VALUE_IN + mv_offset) :
            (eff_start == START_POS_UNCOMP) ? init_offset : MV_W'(comp_value + init_offset);
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         TRIM_INIT_OUT <= 1'b0;
         TRIM_INIT_VALUE_OUT <= '0;
      end
      else
      begin
         TRIM_INIT_OUT <= next_init;
         TRIM_INIT_VALUE_OUT <= next_init_value;
      end
   end

   // status and actuator steering outputs
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         STARTUP_ALLOWED_OUT <= 1'b0;
         SENSOR_READY_OUT <= 1'b0;
         TRIM_ACTIVE_OUT <= 1'b0;
         TRIM_LOCKED_OUT <= 1'b1;
         ALARM_ACTIVE_OUT <= 1'b0;
         CURVE_ONLY_OUT <= 1'b1;
         USE_IGNITION_POSITIONS_OUT <= 1'b1;
         AIR_ABOVE_CURVE_OUT <= 1'b0;
         FUEL_ADJUST_OUT <= 1'b0;
      end
      else
      begin
         SENSOR_READY_OUT <= (heat == H_READY);
         STARTUP_ALLOWED_OUT <= (OXYGEN_OPERATING_MODE_IN == MODE_ALARM_ONLY ||
            OXYGEN_OPERATING_MODE_IN == MODE_TRIM_AND_ALARM) ? (heat == H_READY) : 1'b1;
         TRIM_ACTIVE_OUT <= (state == S_RELEASED) && !load_inhibit && trim_allowed;
         TRIM_LOCKED_OUT <= (state != S_RELEASED);
         ALARM_ACTIVE_OUT <= alarm_mode && running && !load_inhibit &&
            (OXYGEN_OPERATING_MODE_IN != MODE_AUTO_DEACTIVATING || SENSOR_READY_OUT);
         CURVE_ONLY_OUT <= !trim_allowed || load_inhibit || state == S_IDLE;
         USE_IGNITION_POSITIONS_OUT <= (eff_start != START_LOAD_COMP);
         AIR_ABOVE_CURVE_OUT <= (eff_start != START_STANDARD) && running &&
            !load_inhibit;
         FUEL_ADJUST_OUT <= (eff_start != START_STANDARD) && running && !load_inhibit &&
            AIR_AT_LIMIT_IN;
      end
   end
endmodule : o2_trim_release_sequencer

// file: design/o2_seq_pkg.sv
// constants and types for the oxygen trim release sequencer
package o2_seq_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = (TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HEAT_WAIT_MIN = 10;
   localparam int HEAT_WAIT_TICKS = HEAT_WAIT_MIN * 60 * (1000000 / TICK_US);
   localparam int LOAD_W = 10;
   localparam int TEMP_W = 12;
   localparam int MV_W = 16;
   localparam int CNT_W = 32;
   // load in 0.1 % steps, so 5 % absolute is 50
   localparam logic [9:0] LOAD_HYST = 10'h032;
   localparam logic [11:0] SENSOR_OPER_TEMP = 12'h2bc;
   localparam logic [11:0] SENSOR_WARM_TEMP = 12'h2b2;
   localparam logic [7:0] PHASE_IGN_A = 8'h32;
   localparam logic [7:0] PHASE_IGN_B = 8'h36;
   localparam logic [7:0] PHASE_OPER = 8'h3c;
   localparam logic [7:0] RELEASE_TAU_MULT = 8'h04;
   localparam logic [2:0] MODE_MANUAL_OFF = 3'h0;
   localparam logic [2:0] MODE_ALARM_ONLY = 3'h1;
   localparam logic [2:0] MODE_TRIM_AND_ALARM = 3'h2;
   localparam logic [2:0] MODE_AUTO_DEACTIVATING = 3'h3;
   localparam logic [2:0] MODE_AUTO_DEACTIVATED = 3'h4;
   localparam logic [1:0] START_STANDARD = 2'h0;
   localparam logic [1:0] START_LOAD_COMP = 2'h1;
   localparam logic [1:0] START_POS_COMP = 2'h2;
   localparam logic [1:0] START_POS_UNCOMP = 2'h3;
   typedef enum logic [2:0] {S_IDLE, S_START_LOCK, S_PHASE_LOCK, S_INIT_WAIT,
                             S_RELEASED, S_HOLD} seq_state_t;
   typedef enum logic [1:0] {H_COLD, H_SOAK, H_READY} heat_state_t;
endpackage : o2_seq_pkg

// file: design/o2_interval_timer.sv
// tick-driven down counter for locking and release intervals
`timescale 1ns/1ns
module o2_interval_timer
   import o2_seq_pkg::*;
#(
   parameter int W = CNT_W
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tick_in,
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic [W-1:0] count_in,
   output logic busy_out,
   output logic done_out
);
   logic [W-1:0] remain;

   if (W < 8)
   begin : bad_width
      $error("timer width too small");
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || abort_in)
      begin
         remain <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end
      else if (start_in)
      begin
         remain <= count_in;
         busy_out <= 1'b1;
         done_out <= 1'b0;
      end
      else
      begin
         done_out <= 1'b0;
         if (busy_out && tick_in)
         begin
            if (remain <= {{(W-1){1'b0}}, 1'b1})
            begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
            remain <= remain - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule : o2_interval_timer

// file: tb/o2_seq_asserts.sv
// port-level assertions for the trim release sequencer
`timescale 1ns/1ns
module o2_seq_asserts
   import o2_seq_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic FUEL_OIL_IN,
   input wire logic [LOAD_W-1:0] LOAD_IN,
   input wire logic [LOAD_W-1:0] LOWFIRE_ADAPT_POINT_GAS_IN,
   input wire logic [LOAD_W-1:0] TRIM_LOAD_THRESHOLD_GAS_IN,
   input wire logic [2:0] OXYGEN_OPERATING_MODE_IN,
   input wire logic SENSOR_TEST_OK_IN,
   input wire logic AIR_AT_LIMIT_IN,
   input wire logic STARTUP_ALLOWED_OUT,
   input wire logic SENSOR_READY_OUT,
   input wire logic TRIM_ACTIVE_OUT,
   input wire logic TRIM_LOCKED_OUT,
   input wire logic ALARM_ACTIVE_OUT,
   input wire logic CURVE_ONLY_OUT,
   input wire logic TRIM_INIT_OUT,
   input wire logic signed [MV_W-1:0] TRIM_INIT_VALUE_OUT,
   input wire logic USE_IGNITION_POSITIONS_OUT,
   input wire logic AIR_ABOVE_CURVE_OUT,
   input wire logic FUEL_ADJUST_OUT
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);
   // two cycles, since the outputs lag the mode by one edge
   sequence alarm_gate_s;
      ((OXYGEN_OPERATING_MODE_IN == MODE_ALARM_ONLY
         || OXYGEN_OPERATING_MODE_IN == MODE_TRIM_AND_ALARM) && !SENSOR_READY_OUT) [*2];
   endsequence
   sequence plain_mode_s;
      (OXYGEN_OPERATING_MODE_IN != MODE_TRIM_AND_ALARM
         && OXYGEN_OPERATING_MODE_IN != MODE_AUTO_DEACTIVATING) [*2];
   endsequence
   low_fire_off_a:
      assert property (!FUEL_OIL_IN && LOAD_IN < LOWFIRE_ADAPT_POINT_GAS_IN |-> ##2
         !TRIM_ACTIVE_OUT) else $error("trim active below low-fire point");
   threshold_off_a:
      assert property (!FUEL_OIL_IN && LOAD_IN < TRIM_LOAD_THRESHOLD_GAS_IN |-> ##2
         (!TRIM_ACTIVE_OUT && !ALARM_ACTIVE_OUT && CURVE_ONLY_OUT))
         else $error("trim or alarm active below load threshold");
   manual_off_a:
      assert property (OXYGEN_OPERATING_MODE_IN == MODE_MANUAL_OFF |=>
         !TRIM_ACTIVE_OUT && !ALARM_ACTIVE_OUT && CURVE_ONLY_OUT)
         else $error("manual off mode not on curves");
   startup_gate_a:
      assert property (alarm_gate_s |-> !STARTUP_ALLOWED_OUT)
         else $error("startup allowed with cold sensor");
   auto_start_a:
      assert property (OXYGEN_OPERATING_MODE_IN == MODE_AUTO_DEACTIVATING |=> STARTUP_ALLOWED_OUT)
         else $error("auto-deactivating mode held startup");
   test_gate_a:
      assert property (OXYGEN_OPERATING_MODE_IN == MODE_AUTO_DEACTIVATING && !SENSOR_TEST_OK_IN
         |=> !TRIM_ACTIVE_OUT) else $error("trim active without sensor test");
   plain_start_a:
      assert property (plain_mode_s |-> USE_IGNITION_POSITIONS_OUT && !AIR_ABOVE_CURVE_OUT
         && !FUEL_ADJUST_OUT) else $error("special start outside trim modes");
   init_pulse_a:
      assert property (TRIM_INIT_OUT |=> !TRIM_INIT_OUT) else $error("init pulse too long");
   init_hold_a:
      assert property (!TRIM_INIT_OUT |-> $stable(TRIM_INIT_VALUE_OUT))
         else $error("init value moved between pulses");
   active_unlocked_a:
      assert property (TRIM_ACTIVE_OUT |-> !TRIM_LOCKED_OUT) else $error("active while locked");
   fuel_adjust_a:
      assert property (FUEL_ADJUST_OUT |-> $past(AIR_AT_LIMIT_IN))
         else $error("fuel adjusted with air free");
endmodule : o2_seq_asserts
bind o2_trim_release_sequencer o2_seq_asserts chk (.*);

// file: tb/o2_probe_model.sv
// oxygen probe stand-in: slow heater, sensor test, lagging oxygen reading
`timescale 1ns/1ns
module o2_probe_model
   import o2_seq_pkg::*;
(
   input wire logic clk_in,
   input wire logic [TEMP_W-1:0] target_in,
   input wire logic lean_in,
   output logic [TEMP_W-1:0] temp_out,
   output logic test_ok_out,
   output logic below_out
);
   logic [2:0] soak;
   logic [1:0] lag;
   initial
   begin
      temp_out = '0;
      test_ok_out = 1'b0;
      below_out = 1'b0;
      soak = '0;
      lag = '0;
   end
   // heats 20 degrees a cycle but cools at once, so hot restarts are quick
   always @(posedge clk_in)
   begin
      temp_out <= (temp_out + 12'h014 <= target_in) ? temp_out + 12'h014 : target_in;
      soak <= (temp_out < SENSOR_OPER_TEMP) ? 3'h0 : ((soak == 3'h4) ? soak : soak + 3'h1);
      test_ok_out <= (soak == 3'h4);
      lag <= {lag[0], lean_in};
      below_out <= lag[1];
   end
endmodule : o2_probe_model

// file: tb/o2_trim_release_sequencer_tb.sv
// self-checking bench for the trim release sequencer
`timescale 1ns/1ns
module o2_trim_release_sequencer_tb;
   import o2_seq_pkg::*;
   localparam int SUP = 30, ADJ = 20, GAIN = 3;
   logic CLK_IN = 1'b0, RST_B_IN, FUEL_OIL_IN, POWER_RESTORED_IN, AIR_AT_LIMIT_IN, lean;
   logic [9:0] LOAD_IN, LOWFIRE_ADAPT_POINT_GAS_IN, LOWFIRE_ADAPT_POINT_OIL_IN;
   logic [9:0] TRIM_LOAD_THRESHOLD_GAS_IN, TRIM_LOAD_THRESHOLD_OIL_IN;
   logic [2:0] OXYGEN_OPERATING_MODE_IN;
   logic [1:0] START_MODE_IN;
   logic [7:0] PHASE_IN, LOCK_TIME_CONSTANT_MULTIPLE_IN;
   logic [15:0] TAU_LOWFIRE_IN;
   logic [11:0] SENSOR_TEMP_IN, target;
   logic signed [15:0] START_VALUE_IN, MANIPULATED_VALUE_OFFSET_GAS_IN;
   logic signed [15:0] MANIPULATED_VALUE_OFFSET_OIL_IN, INITIALIZATION_OFFSET_GAS_IN;
   logic signed [15:0] INITIALIZATION_OFFSET_OIL_IN, TRIM_INIT_VALUE_OUT;
   logic signed [11:0] SUPPLY_AIR_TEMP_IN, ADJUSTMENT_AIR_TEMPERATURE_IN;
   logic signed [3:0] TEMP_GAIN_IN;
   logic SENSOR_TEST_OK_IN, O2_BELOW_SETPOINT_IN, STARTUP_ALLOWED_OUT, SENSOR_READY_OUT;
   logic TRIM_ACTIVE_OUT, TRIM_LOCKED_OUT, ALARM_ACTIVE_OUT, CURVE_ONLY_OUT, TRIM_INIT_OUT;
   logic USE_IGNITION_POSITIONS_OUT, AIR_ABOVE_CURVE_OUT, FUEL_ADJUST_OUT;
   int checks = 0;
   int err_count = 0;
   // short tick and soak keep the run small
   o2_trim_release_sequencer #(.TICK_CYC(4), .HEAT_TICKS(10)) uut (.*);
   o2_probe_model probe (.clk_in(CLK_IN), .target_in(target), .lean_in(lean),
      .temp_out(SENSOR_TEMP_IN), .test_ok_out(SENSOR_TEST_OK_IN),
      .below_out(O2_BELOW_SETPOINT_IN));
   always #4 CLK_IN = ~CLK_IN;
   task automatic step(input int n);
      repeat (n) @(posedge CLK_IN);
      #1;
   endtask : step
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // sel 0 init pulse, 1 trim active, 2 sensor ready
   task automatic wait_for(input int sel, input int lim, output int n);
      n = 0;
      while ((sel == 0 ? TRIM_INIT_OUT : (sel == 1 ? TRIM_ACTIVE_OUT : SENSOR_READY_OUT)) !== 1'b1)
      begin
         step(1);
         n++;
         if (n > lim)
         begin
            err_count++;
            close_out();
         end
      end
   endtask : wait_for
   task automatic do_reset(input logic warm, input int n);
      RST_B_IN = 1'b0;
      POWER_RESTORED_IN = warm;
      PHASE_IN = 8'h00;
      step(n);
      RST_B_IN = 1'b1;
      step(1);
   endtask : do_reset
   task automatic t_heat();
      int n;
      target = 12'h2ee;
      step(60);
      check({SENSOR_READY_OUT, STARTUP_ALLOWED_OUT}, 2'b00);
      wait_for(2, 60, n);
      check(n + 60 >= 72 && n + 60 <= 86, 1'b1);
      step(2);
      check(STARTUP_ALLOWED_OUT, 1'b1);
   endtask : t_heat
   task automatic t_std();
      int n;
      PHASE_IN = PHASE_IGN_A;
      step(3);
      check({TRIM_LOCKED_OUT, USE_IGNITION_POSITIONS_OUT, TRIM_ACTIVE_OUT}, 3'b110);
      PHASE_IN = PHASE_OPER;
      wait_for(0, 60, n);
      check(n >= 22 && n <= 32, 1'b1);
      check(TRIM_INIT_VALUE_OUT, START_VALUE_IN + MANIPULATED_VALUE_OFFSET_GAS_IN);
      wait_for(1, 60, n);
      check(n >= 30 && n <= 40, 1'b1);
      check({TRIM_LOCKED_OUT, ALARM_ACTIVE_OUT}, 2'b01);
   endtask : t_std
   task automatic t_load();
      int n;
      LOWFIRE_ADAPT_POINT_GAS_IN = 10'h0fa;
      LOAD_IN = 10'h0f0;
      step(3);
      check({TRIM_ACTIVE_OUT, ALARM_ACTIVE_OUT, CURVE_ONLY_OUT}, 3'b001);
      LOAD_IN = 10'h12b;
      step(10);
      check(TRIM_ACTIVE_OUT, 1'b0);
      LOAD_IN = 10'h12c;
      wait_for(0, 10, n);
      wait_for(1, 10, n);
      check(ALARM_ACTIVE_OUT, 1'b1);
      LOWFIRE_ADAPT_POINT_GAS_IN = 10'h0c8;
      TRIM_LOAD_THRESHOLD_GAS_IN = 10'h12c;
      LOAD_IN = 10'h122;
      step(3);
      check({TRIM_ACTIVE_OUT, ALARM_ACTIVE_OUT, CURVE_ONLY_OUT}, 3'b001);
      LOAD_IN = 10'h15e;
      wait_for(1, 20, n);
      check(ALARM_ACTIVE_OUT, 1'b1);
   endtask : t_load
   task automatic t_special();
      int n;
      logic signed [15:0] e;
      for (int sm = 1; sm <= 3; sm++)
      begin
         PHASE_IN = 8'h00;
         FUEL_OIL_IN = (sm == 2);
         step(3);
         START_MODE_IN = 2'(sm);
         PHASE_IN = (sm == 3) ? PHASE_IGN_A : PHASE_IGN_B;
         wait_for(0, 5, n);
         e = (sm == 3) ? 16'sh0000 : 16'((SUP - ADJ) * GAIN);
         e = e + ((sm == 2) ? INITIALIZATION_OFFSET_OIL_IN : INITIALIZATION_OFFSET_GAS_IN);
         check(TRIM_INIT_VALUE_OUT, e);
         step(1);
         check({USE_IGNITION_POSITIONS_OUT, AIR_ABOVE_CURVE_OUT, TRIM_LOCKED_OUT},
            {sm != 1, 2'b11});
         AIR_AT_LIMIT_IN = 1'b1;
         step(2);
         check(FUEL_ADJUST_OUT, 1'b1);
         AIR_AT_LIMIT_IN = 1'b0;
         PHASE_IN = PHASE_OPER;
         lean = (sm == 1);
         step(10);
         check(TRIM_LOCKED_OUT, sm != 1);
         step(20);
         check(TRIM_LOCKED_OUT, 1'b0);
         lean = 1'b0;
      end
      FUEL_OIL_IN = 1'b0;
   endtask : t_special
   task automatic t_gates();
      for (int m = 0; m <= 1; m++)
      begin
         PHASE_IN = 8'h00;
         step(2);
         OXYGEN_OPERATING_MODE_IN = 3'(m);
         START_MODE_IN = START_LOAD_COMP;
         PHASE_IN = PHASE_IGN_A;
         step(3);
         check({USE_IGNITION_POSITIONS_OUT, AIR_ABOVE_CURVE_OUT, TRIM_INIT_OUT}, 3'b100);
         check({ALARM_ACTIVE_OUT, CURVE_ONLY_OUT}, {1'b0, 1'b1} | {m == 1, 1'b0});
      end
   endtask : t_gates
   task automatic t_auto();
      int n;
      target = 12'h000;
      do_reset(1'b0, 10);
      OXYGEN_OPERATING_MODE_IN = MODE_AUTO_DEACTIVATING;
      START_MODE_IN = START_STANDARD;
      step(2);
      check(STARTUP_ALLOWED_OUT, 1'b1);
      PHASE_IN = PHASE_IGN_A;
      step(2);
      PHASE_IN = PHASE_OPER;
      step(70);
      check(TRIM_ACTIVE_OUT, 1'b0);
      target = 12'h2ee;
      wait_for(1, 150, n);
      check(n >= 70, 1'b1);
      target = 12'h2b7;
      do_reset(1'b1, 40);
      step(2);
      check(SENSOR_READY_OUT, 1'b1);
   endtask : t_auto
   initial
   begin
      {FUEL_OIL_IN, AIR_AT_LIMIT_IN, lean, POWER_RESTORED_IN} = '0;
      LOAD_IN = 10'h1f4;
      LOWFIRE_ADAPT_POINT_GAS_IN = 10'h0c8;
      LOWFIRE_ADAPT_POINT_OIL_IN = 10'h064;
      TRIM_LOAD_THRESHOLD_GAS_IN = 10'h064;
      TRIM_LOAD_THRESHOLD_OIL_IN = 10'h064;
      OXYGEN_OPERATING_MODE_IN = MODE_TRIM_AND_ALARM;
      START_MODE_IN = START_STANDARD;
      LOCK_TIME_CONSTANT_MULTIPLE_IN = 8'h03;
      TAU_LOWFIRE_IN = 16'h0002;
      START_VALUE_IN = 16'sh0100;
      SUPPLY_AIR_TEMP_IN = 12'(SUP);
      ADJUSTMENT_AIR_TEMPERATURE_IN = 12'(ADJ);
      TEMP_GAIN_IN = 4'(GAIN);
      MANIPULATED_VALUE_OFFSET_GAS_IN = 16'sh0020;
      MANIPULATED_VALUE_OFFSET_OIL_IN = 16'sh0030;
      INITIALIZATION_OFFSET_GAS_IN = 16'shfffb;
      INITIALIZATION_OFFSET_OIL_IN = 16'sh0007;
      target = 12'h000;
      do_reset(1'b0, 10);
      check({TRIM_LOCKED_OUT, CURVE_ONLY_OUT, USE_IGNITION_POSITIONS_OUT, TRIM_ACTIVE_OUT,
         ALARM_ACTIVE_OUT, TRIM_INIT_OUT}, 6'b111000);
      t_heat();
      t_std();
      t_load();
      t_special();
      t_gates();
      t_auto();
      close_out();
   end
endmodule : o2_trim_release_sequencer_tb
